/* File: eiq_chk.sv */
// Assertion checker for the external interrupt noise filter
`include "eiq_params.svh"
`default_nettype none
module eiq_chk import eiq_pkg::*; (
  input wire logic        clk_i,
  input wire logic        srst_i,
  input wire logic        ext_irq_a_pin_i,
  input wire logic        ext_irq_b_pin_i,
  input wire logic        pin_a_is_output_i,
  input wire logic        pin_b_is_output_i,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        irq_a_req_o,
  input wire logic        irq_b_req_o,
  input wire logic        irq_o
);
  logic        wr_q, rd_q, gate_q;
  logic [31:0] ad_q;
  logic [3:0]  ctrl_q;
  logic [2:0]  mode_q;
  logic [1:0]  mask_q;
  logic        ain, bin, fast, deep;
  // Pin in output mode reads low inside
  assign ain  = ext_irq_a_pin_i & ~pin_a_is_output_i;
  assign bin  = ext_irq_b_pin_i & ~pin_b_is_output_i;
  assign fast = gate_q && (mode_q <= EIQ_MODE_IDLE);
  assign deep = mode_q >= EIQ_MODE_IDLE_DEEP_MODE;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Shadow of the writes, so mode-dependent checks need no internals
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      {wr_q, rd_q, ad_q, gate_q, ctrl_q, mask_q, mode_q} <= '0;
    end
    else
    begin
      wr_q <= hsel & hready & htrans[1] & hwrite;
      rd_q <= hsel & hready & htrans[1] & ~hwrite;
      ad_q <= haddr;
      if (wr_q && ad_q == `EIQ_ADDR_CTRL) ctrl_q <= hwdata[3:0];
      if (wr_q && ad_q == `EIQ_ADDR_GATE) gate_q <= hwdata[0];
      if (wr_q && ad_q == `EIQ_ADDR_MASK) mask_q <= hwdata[1:0];
      if (wr_q && ad_q == `EIQ_ADDR_MODE && hwdata <= 32'h0000_0006) mode_q <= hwdata[2:0];
    end
  end
  a_bus_idle: assert property (hreadyout && !hresp && (rd_q || hrdata == 32'h0000_0000))
    else $error("bus answer or idle read data wrong");
  a_deep_quiet: assert property (deep [*3] |-> !irq_a_req_o && !irq_b_req_o)
    else $error("request while sampling halted");
  a_gate_quiet: assert property (!gate_q [*3] |-> !irq_a_req_o && !irq_b_req_o)
    else $error("request while clock gated");
  a_b_two_low: assert property (fast && irq_b_req_o |-> !$past(bin, 2) && !$past(bin, 3))
    else $error("second pin request without two low samples");
  a_a_rise_three: assert property (fast && ctrl_q == 4'h0 && irq_a_req_o
    |-> $past(ain, 2) && $past(ain, 3) && $past(ain, 4))
    else $error("rise request without three high samples");
  a_a_fall_three: assert property (fast && ctrl_q == 4'h1 && irq_a_req_o
    |-> !$past(ain, 2) && !$past(ain, 3) && !$past(ain, 4))
    else $error("fall request without three low samples");
  a_irq_raise: assert property (irq_a_req_o && mask_q[0] |-> ##[0:1] irq_o)
    else $error("unmasked request did not raise interrupt");
  a_irq_masked: assert property (mask_q == 2'h0 |-> !irq_o)
    else $error("interrupt while all masked");
endmodule
bind eiq_top eiq_chk chk (.*);
`default_nettype wire

/* File: eiq_filter.sv */
// Consecutive-sample glitch filter, count of equal samples selectable
`default_nettype none
module eiq_filter (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       en_i,
  input  wire logic       sample_i,
  input  wire logic       din_i,
  input  wire logic [3:0] hits_i,
  input  wire logic       flush_i,
  output logic            dout_o
);
  logic [3:0] run_reg;
  logic       last_reg;

  always_ff @(posedge clk_i)
  begin
    if (srst_i || flush_i)
    begin
      run_reg  <= 4'h0;
      last_reg <= 1'b1;
      dout_o   <= 1'b1;
    end
    else if (en_i && sample_i)
    begin
      last_reg <= din_i;
      if (din_i != last_reg)
        run_reg <= 4'h1;
      else if (run_reg < hits_i)
        run_reg <= run_reg + 4'h1;
      // Output moves only once the run reaches the threshold
      if ((din_i == last_reg) && (run_reg + 4'h1 >= hits_i))
        dout_o <= din_i;
    end
  end
endmodule
`default_nettype wire

/* File: eiq_params.svh */
// Constants for the external interrupt noise filter
`ifndef EIQ_PARAMS_SVH
`define EIQ_PARAMS_SVH
`define EIQ_ADDR_CTRL      32'h0000_0000
`define EIQ_ADDR_GATE      32'h0000_0004
`define EIQ_ADDR_STATUS    32'h0000_0008
`define EIQ_ADDR_MASK      32'h0000_000C
`define EIQ_ADDR_MODE      32'h0000_0010
`define EIQ_CTRL_ES_LSB    0
`define EIQ_CTRL_NC_LSB    2
`define EIQ_CTRL_LVL_BIT   4
`define EIQ_CTRL_RST       2'h0
`define EIQ_GATE_RST       1'h0
`define EIQ_MASK_RST       2'h0
`define EIQ_MODE_RST       3'h0
`define EIQ_LF_DIV         4
`define EIQ_A_FAST_HITS    3
`define EIQ_A_SLOW_HITS    2
`define EIQ_B_FAST_HITS    2
`define EIQ_B_SLOW_HITS    8
`endif

/* File: eiq_pkg.sv */
// Types for the external interrupt noise filter
`default_nettype none
package eiq_pkg;
  typedef enum logic [1:0] {
    EIQ_TRIG_RISE,
    EIQ_TRIG_FALL,
    EIQ_TRIG_BOTH,
    EIQ_TRIG_HIGH
  } eiq_trig_t;
  typedef enum logic [2:0] {
    EIQ_MODE_NORMAL,
    EIQ_MODE_IDLE,
    EIQ_MODE_SLOW,
    EIQ_MODE_SLEEP_LOW_CLOCK_MODE,
    EIQ_MODE_IDLE_DEEP_MODE,
    EIQ_MODE_SLEEP_DEEP_MODE,
    EIQ_MODE_STOP
  } eiq_mode_t;
endpackage
`default_nettype wire

/* File: eiq_src.sv */
// Behavioural sources driving both external interrupt pins
`default_nettype none
module eiq_src (
  input  wire logic clk_i,
  output logic      pin_a_o  = 1'b1,
  output logic      pin_b_o  = 1'b1,
  output logic      lf_clk_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Low clock runs free, ten fast cycles a period
  always
  begin
    repeat (5) @(posedge clk_i);
    lf_clk_o <= ~lf_clk_o;
  end
  // Whole-cycle levels; glitches kept apart so the filter can judge them
  task automatic drive(input logic a, input logic b, input int n);
    pin_a_o <= a;
    pin_b_o <= b;
    repeat (n) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* File: eiq_top.sv */
// External interrupt noise filter with AHB-Lite register slave
//
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`include "eiq_params.svh"
`default_nettype none
module eiq_top (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        ce_i,
  input  wire logic        ext_irq_a_pin_i,
  input  wire logic        ext_irq_b_pin_i,
  input  wire logic        pin_a_is_output_i,
  input  wire logic        pin_b_is_output_i,
  input  wire logic        low_freq_clock_i,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             irq_a_req_o,
  output logic             irq_b_req_o,
  output logic             irq_o
);
  import eiq_pkg::*;

  eiq_trig_t  trigger_condition_select_reg;
  logic [1:0] sample_interval_select_reg;
  logic       filtered_level_capture_reg;
  logic       irq_clock_gate_reg;
  logic [1:0] status_reg;
  logic [1:0] mask_reg;
  eiq_mode_t  mode_reg;
  logic       wr_pend_reg;
  logic       rd_pend_reg;
  logic [4:0] addr_reg;
  logic [3:0] div_reg;
  logic [1:0] lf_cnt_reg;
  logic       lf_d1_reg;
  logic       lf_d2_reg;
  logic       lf_d3_reg;
  logic       a_last_reg;
  logic       b_last_reg;

  logic       run;
  logic       fast;
  logic       slow;
  logic       lf_rise;
  logic       lf_tick;
  logic       a_tick;
  logic       a_din;
  logic       b_din;
  logic       a_flt;
  logic       b_flt;
  logic [3:0] a_hits;
  logic [3:0] b_hits;
  logic       a_hit;
  logic       b_hit;
  logic       take;
  logic       rd_status;

  // Gate and mode decide whether the dividers and filters may run
  assign fast = (mode_reg == EIQ_MODE_NORMAL) || (mode_reg == EIQ_MODE_IDLE);
  assign slow = (mode_reg == EIQ_MODE_SLOW) || (mode_reg == EIQ_MODE_SLEEP_LOW_CLOCK_MODE);
  assign run  = ce_i && irq_clock_gate_reg && (fast || slow);

  // Pin in output mode reads low
  assign a_din = ext_irq_a_pin_i && !pin_a_is_output_i;
  assign b_din = ext_irq_b_pin_i && !pin_b_is_output_i;

  // Low clock is slow; two stages before edge detection
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      lf_d1_reg <= 1'b0;
      lf_d2_reg <= 1'b0;
      lf_d3_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      lf_d1_reg <= low_freq_clock_i;
      lf_d2_reg <= lf_d1_reg;
      lf_d3_reg <= lf_d2_reg;
    end
  end
  assign lf_rise = lf_d2_reg && !lf_d3_reg;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      lf_cnt_reg <= 2'h0;
    else if (run && slow && lf_rise)
      lf_cnt_reg <= lf_cnt_reg + 2'h1;
  end
  assign lf_tick = slow && lf_rise && (lf_cnt_reg == 2'(`EIQ_LF_DIV - 1));

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      div_reg <= 4'h0;
    else if (run && fast)
      div_reg <= div_reg + 4'h1;
  end

  always_comb
  begin
    unique case (sample_interval_select_reg)
      2'b00: a_tick = 1'b1;
      2'b01: a_tick = (div_reg[1:0] == 2'h0);
      2'b10: a_tick = (div_reg[2:0] == 3'h0);
      2'b11: a_tick = (div_reg == 4'h0);
    endcase
  end

  assign a_hits = fast ? 4'(`EIQ_A_FAST_HITS) : 4'(`EIQ_A_SLOW_HITS);
  // Two equal clock samples reject one-cycle glitches
  assign b_hits = fast ? 4'(`EIQ_B_FAST_HITS) : 4'(`EIQ_B_SLOW_HITS);

  eiq_filter u_flt_a (
    .clk_i    (clk_i),
    .srst_i   (srst_i),
    .en_i     (run),
    .sample_i (fast ? a_tick : lf_tick),
    .din_i    (a_din),
    .hits_i   (a_hits),
    .flush_i  (ce_i && !irq_clock_gate_reg),
    .dout_o   (a_flt)
  );

  // Slow-mode second pin sampled every low clock rising edge, eight in a row
  eiq_filter u_flt_b (
    .clk_i    (clk_i),
    .srst_i   (srst_i),
    .en_i     (run),
    .sample_i (fast ? 1'b1 : lf_rise),
    .din_i    (b_din),
    .hits_i   (b_hits),
    .flush_i  (ce_i && !irq_clock_gate_reg),
    .dout_o   (b_flt)
  );

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      a_last_reg <= 1'b1;
      b_last_reg <= 1'b1;
    end
    else if (run)
    begin
      a_last_reg <= a_flt;
      b_last_reg <= b_flt;
    end
  end

  always_comb
  begin
    unique case (trigger_condition_select_reg)
      EIQ_TRIG_RISE: a_hit = a_flt && !a_last_reg;
      EIQ_TRIG_FALL: a_hit = !a_flt && a_last_reg;
      EIQ_TRIG_BOTH: a_hit = a_flt != a_last_reg;
      EIQ_TRIG_HIGH: a_hit = a_flt && a_tick_or_lf();
    endcase
  end

  // High level requests once per sample while high
  function automatic logic a_tick_or_lf();
    return fast ? a_tick : lf_tick;
  endfunction

  assign b_hit = !b_flt && b_last_reg;

  // One-cycle requests, back to back for a high level sampled every cycle; nothing while halted
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      irq_a_req_o <= 1'b0;
      irq_b_req_o <= 1'b0;
    end
    else if (ce_i)
    begin
      irq_a_req_o <= run && a_hit;
      irq_b_req_o <= run && b_hit;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      filtered_level_capture_reg <= 1'b0;
    else if (run && a_hit)
      filtered_level_capture_reg <= a_flt;
  end

  // AHB-Lite slave, zero wait states, always OKAY
  assign take      = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign rd_status = rd_pend_reg && (32'(addr_reg) == `EIQ_ADDR_STATUS);

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 5'h00;
    end
    else if (ce_i)
    begin
      // Upper address bits decoded so holes do not alias the registers
      wr_pend_reg <= take && hwrite && (haddr[31:5] == 27'h000_0000);
      rd_pend_reg <= take && !hwrite && (haddr[31:5] == 27'h000_0000);
      if (take)
        addr_reg <= haddr[4:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      trigger_condition_select_reg <= EIQ_TRIG_RISE;
      sample_interval_select_reg   <= `EIQ_CTRL_RST;
      irq_clock_gate_reg           <= `EIQ_GATE_RST;
      mask_reg                     <= `EIQ_MASK_RST;
      mode_reg                     <= EIQ_MODE_NORMAL;
    end
    else if (ce_i && wr_pend_reg)
    begin
      unique case (32'(addr_reg))
        `EIQ_ADDR_CTRL:
        begin
          trigger_condition_select_reg <= eiq_trig_t'(hwdata[`EIQ_CTRL_ES_LSB +: 2]);
          sample_interval_select_reg   <= hwdata[`EIQ_CTRL_NC_LSB +: 2];
        end
        `EIQ_ADDR_GATE: irq_clock_gate_reg <= hwdata[0];
        `EIQ_ADDR_MASK: mask_reg <= hwdata[1:0];
        `EIQ_ADDR_MODE:
          if (hwdata[2:0] <= 3'h6)
            mode_reg <= eiq_mode_t'(hwdata[2:0]);
        default: ;
      endcase
    end
  end

  // Set wins over clear-on-read
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      status_reg <= 2'h0;
    else if (ce_i)
      status_reg <= (rd_status ? 2'h0 : status_reg) | {irq_b_req_o, irq_a_req_o};
  end

  always_comb
  begin
    hrdata = 32'h0000_0000;
    if (rd_pend_reg)
    begin
      unique case (32'(addr_reg))
        `EIQ_ADDR_CTRL:
        begin
          hrdata[`EIQ_CTRL_ES_LSB +: 2] = trigger_condition_select_reg;
          hrdata[`EIQ_CTRL_NC_LSB +: 2] = sample_interval_select_reg;
          hrdata[`EIQ_CTRL_LVL_BIT]     = filtered_level_capture_reg;
        end
        `EIQ_ADDR_GATE:   hrdata[0]   = irq_clock_gate_reg;
        `EIQ_ADDR_STATUS: hrdata[1:0] = status_reg;
        `EIQ_ADDR_MASK:   hrdata[1:0] = mask_reg;
        `EIQ_ADDR_MODE:   hrdata[2:0] = mode_reg;
        default:          hrdata      = 32'h0000_0000;
      endcase
    end
  end

  assign irq_o = |(status_reg & mask_reg);
endmodule
`default_nettype wire

/* File: ext_irq_noise_filter_tb_top.sv */
// Testbench for the external interrupt noise filter
`default_nettype none
`define CHK(n, e, a) \
  begin \
    checked++; \
    if ((a) !== (e)) \
    begin \
      num_errors++; \
      $display("mismatch %s expected %0h seen %0h", n, e, a); \
    end \
  end
module ext_irq_noise_filter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import eiq_pkg::*;
  logic        clk_i = 0, srst_i = 1, pa_out = 0, pb_out = 0, hsel = 0, hwrite = 0;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  wire  logic [31:0] hrdata;
  wire  logic        hreadyout, hresp, irq_a_req_o, irq_b_req_o, irq_o, pa, pb, lf;
  int          num_errors = 0, checked = 0, na = 0, nb = 0, d;
  int          ea[4] = '{1, 1, 2, 10};
  logic        lv[4] = '{1, 0, 0, 1};
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    na += int'(irq_a_req_o === 1'b1);
    nb += int'(irq_b_req_o === 1'b1);
  end
  eiq_src src (.clk_i(clk_i), .pin_a_o(pa), .pin_b_o(pb), .lf_clk_o(lf));
  eiq_top uut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .ext_irq_a_pin_i(pa),
    .ext_irq_b_pin_i(pb), .pin_a_is_output_i(pa_out), .pin_b_is_output_i(pb_out),
    .low_freq_clock_i(lf), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq_a_req_o(irq_a_req_o),
    .irq_b_req_o(irq_b_req_o), .irq_o(irq_o));
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] v);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk_i); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= v;
    do @(posedge clk_i); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge clk_i);
    num_errors++;
    results();
  end
  initial
  begin
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    bus(0, 32'h0000_0004, 0); `CHK("gate", 32'h0000_0000, rd)
    bus(0, 32'h0000_0020, 0); `CHK("hole", 32'h0000_0000, rd)
    src.drive(1, 0, 10); src.drive(0, 1, 10); `CHK("gated", 0, na + nb)
    $display("test reset done");
    bus(1, 32'h0000_0004, 1); bus(1, 32'h0000_000C, 3); src.drive(0, 1, 10);
    for (int es = 0; es < 4; es++)
    begin
      bus(1, 32'h0000_0000, es); bus(0, 32'h0000_0008, 0); na = 0;
      src.drive(1, 1, 10); src.drive(0, 1, 10); bus(0, 32'h0000_0000, 0);
      `CHK("trigger", ea[es], na)
      `CHK("level", lv[es], rd[4])
    end
    `CHK("irq set", 1'b1, irq_o)
    bus(0, 32'h0000_0008, 0); `CHK("status", 32'h0000_0001, rd)
    @(posedge clk_i);
    `CHK("irq clear", 1'b0, irq_o)
    $display("test trigger done");
    for (int nc = 0; nc < 4; nc++)
    begin
      d = (nc == 0) ? 1 : (2 << nc);
      bus(1, 32'h0000_0000, nc << 2); na = 0;
      src.drive(1, 1, 2 * d - 1); src.drive(0, 1, 4 * d);
      src.drive(1, 1, 3 * d); src.drive(0, 1, 4 * d); `CHK("interval", 1, na)
    end
    $display("test interval done");
    bus(1, 32'h0000_000C, 1); bus(0, 32'h0000_0008, 0); nb = 0;
    src.drive(0, 0, 1); src.drive(0, 1, 6); src.drive(0, 0, 2); src.drive(0, 1, 6);
    `CHK("b fast", 1, nb)
    `CHK("masked", 1'b0, irq_o)
    bus(0, 32'h0000_0008, 0); `CHK("status b", 32'h0000_0002, rd)
    bus(1, 32'h0000_0000, 1); src.drive(1, 1, 8); na = 0; nb = 0;
    pa_out <= 1'b1; pb_out <= 1'b1; src.drive(1, 1, 8);
    `CHK("out mode", 2, na + nb)
    pa_out <= 1'b0; pb_out <= 1'b0; src.drive(0, 1, 8);
    $display("test pin b done");
    bus(1, 32'h0000_0010, 32'(EIQ_MODE_SLOW)); src.drive(0, 1, 120);
    bus(1, 32'h0000_0000, 0); bus(0, 32'h0000_0008, 0); na = 0; nb = 0;
    src.drive(1, 0, 30); src.drive(0, 1, 60); src.drive(1, 0, 90); src.drive(0, 1, 100);
    `CHK("a slow", 1, na)
    `CHK("b slow", 1, nb)
    bus(1, 32'h0000_0010, 0); src.drive(0, 1, 5); bus(0, 32'h0000_0008, 0);
    $display("test slow done");
    for (int m = 4; m < 7; m++)
    begin
      bus(1, 32'h0000_0010, m); na = 0; nb = 0;
      src.drive(1, 0, 20); src.drive(0, 1, 20); `CHK("deep", 0, na + nb)
    end
    bus(1, 32'h0000_0010, 7); bus(0, 32'h0000_0010, 0); `CHK("mode", 32'h0000_0006, rd)
    bus(1, 32'h0000_0010, 0); src.drive(0, 1, 5); nb = 0;
    src.drive(0, 0, 4); src.drive(0, 1, 6); `CHK("resume", 1, nb)
    $display("test deep done");
    results();
  end
endmodule
`default_nettype wire
